// ### logic/cap_filter_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the capacitive sensing filter block.
// Assumes a 40 MHz system clock; included by its bare name.
`ifndef CAP_FILTER_DEFINES_SVH
`define CAP_FILTER_DEFINES_SVH

`define ADDR_FRONT_END_CONFIG 8'h5c
`define ADDR_FILTER_CONFIG 8'h5d
`define ADDR_RANGE_FAIL_STATUS 8'h01

`define FE_FIRST_COUNT_MSB 7
`define FE_FIRST_COUNT_LSB 6
`define FE_CURRENT_MSB 5
`define FE_CURRENT_LSB 0
`define FC_CHARGE_TIME_MSB 7
`define FC_CHARGE_TIME_LSB 5
`define FC_SECOND_COUNT_MSB 4
`define FC_SECOND_COUNT_LSB 3
`define FC_INTERVAL_MSB 2
`define FC_INTERVAL_LSB 0

`define ST_RECONFIG_BIT 7
`define ST_INITIAL_BIT 6
`define ST_PROX_BIT 4

`define RST_FRONT_END_CONFIG 8'h10
`define RST_FILTER_CONFIG 8'h24

`define CLK_FREQ_HZ 40000000
`define CHARGE_TIME_BASE_NS 500
`define CHARGE_BASE_CYCLES \
    ((`CHARGE_TIME_BASE_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define SAMPLE_INTERVAL_BASE_MS 1
`define INTERVAL_BASE_CYCLES \
    (`SAMPLE_INTERVAL_BASE_MS * (`CLK_FREQ_HZ / 1000))

`endif

// ### logic/cap_filter_pkg.sv
// Types shared by the capacitive sensing filter block.
// Assumes nothing beyond a SystemVerilog compiler.
package cap_filter_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CHARGE = 5'b00010,
        ST_CAPTURE = 5'b00100,
        ST_WAIT_FIRST = 5'b01000,
        ST_DIVIDE = 5'b10000
    } state_type;

endpackage

// ### logic/first_stage_filter.sv
// First-stage filter: collects a burst of raw samples, drops the largest
// and smallest and averages the rest.
// Assumes the caller pulses start before each burst.
`timescale 1ns/1ps
`include "cap_filter_defines.svh"

module first_stage_filter #(
    parameter int DATA_W = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [1:0] count_code,
    input wire logic in_valid,
    input wire logic [DATA_W-1:0] in_data,
    output logic out_valid,
    output logic [DATA_W-1:0] out_data
);
    logic [DATA_W+5:0] sum_q;
    logic [DATA_W-1:0] max_q;
    logic [DATA_W-1:0] min_q;
    logic [5:0] cnt_q;
    logic [5:0] target;
    logic [DATA_W+5:0] trimmed;

    // Totals of 6/10/18/34 leave 4/8/16/32 after trimming: a plain shift
    always_comb begin
        case (count_code)
            2'h0: target = 6'h06;
            2'h1: target = 6'h0a;
            2'h2: target = 6'h12;
            default: target = 6'h22;
        endcase
        trimmed = sum_q - (DATA_W+6)'(max_q) - (DATA_W+6)'(min_q);
    end

    always_ff @(posedge clk) begin
        if (reset || start) begin
            sum_q <= '0;
            max_q <= '0;
            min_q <= '1;
            cnt_q <= 6'h00;
        end else if (in_valid) begin
            sum_q <= sum_q + (DATA_W+6)'(in_data);
            if (in_data > max_q) max_q <= in_data;
            if (in_data < min_q) min_q <= in_data;
            cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= 1'b0;
            if (!start && !in_valid && cnt_q == target && !out_valid) begin
                out_valid <= 1'b1;
                // Three bits: codes 2 and 3 need shifts of 4 and 5
                out_data <= DATA_W'(trimmed >> ({1'b0, count_code} + 3'h2));
            end
        end
    end
endmodule

// ### logic/cap_sense_filter_timing.sv
// Sampling timing, two-stage filtering, touch decision and the
// range-failure status for electrodes 8-11 and the proximity channel.
// Assumes a synchronous single-cycle register port, a front end that
// presents a conversion on ADC_DATA at the end of each charge phase, and
// an auto-configuration engine that reports results on RANGE_FAIL_*.
`timescale 1ns/1ps
`include "cap_filter_defines.svh"

module cap_sense_filter_timing #(
    parameter int DATA_W = 10,
    parameter int unsigned INTERVAL_BASE_CYCLES = `INTERVAL_BASE_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic [DATA_W-1:0] ADC_DATA,
    output logic CHARGE_EN,
    output logic [5:0] CHARGE_CURRENT,
    input wire logic RANGE_FAIL_DONE,
    input wire logic RANGE_FAIL_RECONFIG,
    input wire logic [4:0] RANGE_FAIL_IN,
    input wire logic [DATA_W-1:0] BASELINE,
    input wire logic [DATA_W-1:0] TOUCH_THRESHOLD,
    output logic [DATA_W-1:0] FILTERED_DATA,
    output logic FILTERED_VALID,
    output logic TOUCH
);
    localparam int SUM_W = DATA_W + 5;
    localparam int BASE_W = $clog2(INTERVAL_BASE_CYCLES + 1);

    logic [7:0] front_end_config_q;
    logic [7:0] filter_config_q;
    logic [7:0] status_q;
    cap_filter_pkg::state_type state_q;

    logic [1:0] first_code;
    logic [5:0] current_code;
    logic [2:0] time_code;
    logic [1:0] second_code;
    logic [2:0] interval_code;

    logic [BASE_W-1:0] base_cnt_q;
    logic [7:0] ms_cnt_q;
    logic interval_tick_q;
    logic [11:0] charge_cnt_q;
    logic [11:0] charge_cycles;
    logic [5:0] raw_cnt_q;
    logic [5:0] raw_target;
    logic [4:0] second_cnt_q;
    logic [4:0] second_target;
    logic [SUM_W-1:0] second_sum_q;
    logic [SUM_W-1:0] rem_q;
    logic [SUM_W-1:0] quot_q;
    logic [3:0] div_bit_q;
    logic [SUM_W-1:0] rem_shift;
    logic burst_start_q;
    logic sample_valid_q;
    logic [DATA_W-1:0] sample_q;
    logic first_valid;
    logic [DATA_W-1:0] first_data;

    assign first_code =
        front_end_config_q[`FE_FIRST_COUNT_MSB:`FE_FIRST_COUNT_LSB];
    assign current_code = front_end_config_q[`FE_CURRENT_MSB:`FE_CURRENT_LSB];
    assign time_code =
        filter_config_q[`FC_CHARGE_TIME_MSB:`FC_CHARGE_TIME_LSB];
    assign second_code =
        filter_config_q[`FC_SECOND_COUNT_MSB:`FC_SECOND_COUNT_LSB];
    assign interval_code = filter_config_q[`FC_INTERVAL_MSB:`FC_INTERVAL_LSB];

    always_comb begin
        case (first_code)
            2'h0: raw_target = 6'h06;
            2'h1: raw_target = 6'h0a;
            2'h2: raw_target = 6'h12;
            default: raw_target = 6'h22;
        endcase
        case (second_code)
            2'h0: second_target = 5'h04;
            2'h1: second_target = 5'h06;
            2'h2: second_target = 5'h0a;
            default: second_target = 5'h12;
        endcase
        // 0.5 us base doubled per code step; code 0 never reaches here
        charge_cycles = 12'(`CHARGE_BASE_CYCLES) << (time_code - 3'h1);
        rem_shift = {rem_q[SUM_W-2:0], second_sum_q[div_bit_q]};
    end

    // Register port: front-end and filter configuration are read/write
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            front_end_config_q <= `RST_FRONT_END_CONFIG;
            filter_config_q <= `RST_FILTER_CONFIG;
        end else if (REG_WR) begin
            if (REG_ADDR == `ADDR_FRONT_END_CONFIG) begin
                front_end_config_q <= REG_WDATA;
            end
            if (REG_ADDR == `ADDR_FILTER_CONFIG) begin
                filter_config_q <= REG_WDATA;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `ADDR_FRONT_END_CONFIG: REG_RDATA <= front_end_config_q;
                `ADDR_FILTER_CONFIG: REG_RDATA <= filter_config_q;
                `ADDR_RANGE_FAIL_STATUS: REG_RDATA <= status_q;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // Status is read-only; each completed auto-configuration run replaces it
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_fail
            always_ff @(posedge CLK_SYS) begin
                if (RESET) begin
                    status_q[gi] <= 1'b0;
                end else if (RANGE_FAIL_DONE) begin
                    status_q[gi] <= RANGE_FAIL_IN[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            status_q[7:5] <= 3'h0;
        end else if (RANGE_FAIL_DONE) begin
            status_q[`ST_RECONFIG_BIT] <= RANGE_FAIL_RECONFIG
                && (|RANGE_FAIL_IN);
            status_q[`ST_INITIAL_BIT] <= !RANGE_FAIL_RECONFIG
                && (|RANGE_FAIL_IN);
            status_q[5] <= 1'b0;
        end
    end

    // Interval timer: a 1 ms prescaler, then a count of 2^code ticks
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            base_cnt_q <= '0;
            ms_cnt_q <= 8'h00;
            interval_tick_q <= 1'b0;
        end else begin
            interval_tick_q <= 1'b0;
            if (base_cnt_q == BASE_W'(INTERVAL_BASE_CYCLES - 1)) begin
                base_cnt_q <= '0;
                // At or past the end, so a shorter interval written
                // mid-count does not wait for the counter to wrap
                if (ms_cnt_q >= 8'((9'h001 << interval_code) - 9'h001)) begin
                    ms_cnt_q <= 8'h00;
                    interval_tick_q <= 1'b1;
                end else begin
                    ms_cnt_q <= ms_cnt_q + 8'h01;
                end
            end else begin
                base_cnt_q <= base_cnt_q + BASE_W'(1);
            end
        end
    end

    // Burst sequencer: one burst of raw samples per interval tick.
    // A tick that lands while a burst or divide is busy is dropped, so a
    // very long charge time simply stretches the effective interval.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_q <= cap_filter_pkg::ST_IDLE;
            charge_cnt_q <= 12'h000;
            raw_cnt_q <= 6'h00;
            burst_start_q <= 1'b0;
            sample_valid_q <= 1'b0;
            sample_q <= '0;
            CHARGE_EN <= 1'b0;
        end else begin
            burst_start_q <= 1'b0;
            sample_valid_q <= 1'b0;
            case (state_q)
                cap_filter_pkg::ST_IDLE: begin
                    // No current or an invalid time means no measurement
                    if (interval_tick_q && current_code != 6'h00
                            && time_code != 3'h0) begin
                        state_q <= cap_filter_pkg::ST_CHARGE;
                        burst_start_q <= 1'b1;
                        raw_cnt_q <= 6'h00;
                        charge_cnt_q <= 12'h000;
                        CHARGE_EN <= 1'b1;
                    end
                end
                cap_filter_pkg::ST_CHARGE: begin
                    if (charge_cnt_q == charge_cycles - 12'h001) begin
                        state_q <= cap_filter_pkg::ST_CAPTURE;
                        CHARGE_EN <= 1'b0;
                    end else begin
                        charge_cnt_q <= charge_cnt_q + 12'h001;
                    end
                end
                cap_filter_pkg::ST_CAPTURE: begin
                    sample_q <= ADC_DATA;
                    sample_valid_q <= 1'b1;
                    charge_cnt_q <= 12'h000;
                    raw_cnt_q <= raw_cnt_q + 6'h01;
                    if (raw_cnt_q == raw_target - 6'h01) begin
                        state_q <= cap_filter_pkg::ST_WAIT_FIRST;
                    end else begin
                        state_q <= cap_filter_pkg::ST_CHARGE;
                        CHARGE_EN <= 1'b1;
                    end
                end
                cap_filter_pkg::ST_WAIT_FIRST: begin
                    if (first_valid) begin
                        if (second_cnt_q == second_target - 5'h01) begin
                            state_q <= cap_filter_pkg::ST_DIVIDE;
                        end else begin
                            state_q <= cap_filter_pkg::ST_IDLE;
                        end
                    end
                end
                cap_filter_pkg::ST_DIVIDE: begin
                    if (div_bit_q == 4'h0) begin
                        state_q <= cap_filter_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= cap_filter_pkg::ST_IDLE;
                    CHARGE_EN <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            CHARGE_CURRENT <= 6'h00;
        end else begin
            CHARGE_CURRENT <= current_code;
        end
    end

    first_stage_filter #(
        .DATA_W(DATA_W)
    ) u_first (
        .clk(CLK_SYS),
        .reset(RESET),
        .start(burst_start_q),
        .count_code(first_code),
        .in_valid(sample_valid_q),
        .in_data(sample_q),
        .out_valid(first_valid),
        .out_data(first_data)
    );

    // Second stage: accumulate first-stage results, then divide by count
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            second_sum_q <= '0;
            second_cnt_q <= 5'h00;
        end else if (state_q == cap_filter_pkg::ST_WAIT_FIRST && first_valid) begin
            second_sum_q <= second_sum_q + SUM_W'(first_data);
            second_cnt_q <= second_cnt_q + 5'h01;
        end else if (state_q == cap_filter_pkg::ST_DIVIDE && div_bit_q == 4'h0) begin
            second_sum_q <= '0;
            second_cnt_q <= 5'h00;
        end
    end

    // Restoring divide, one quotient bit per cycle; counts 6, 10 and 18 are not powers
    // of two, and a serial divider is far smaller than a combinational one
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            rem_q <= '0;
            quot_q <= '0;
            div_bit_q <= 4'h0;
        end else if (state_q == cap_filter_pkg::ST_WAIT_FIRST) begin
            rem_q <= '0;
            quot_q <= '0;
            div_bit_q <= 4'(SUM_W - 1);
        end else if (state_q == cap_filter_pkg::ST_DIVIDE) begin
            if (rem_shift >= SUM_W'(second_target)) begin
                rem_q <= rem_shift - SUM_W'(second_target);
                quot_q <= {quot_q[SUM_W-2:0], 1'b1};
            end else begin
                rem_q <= rem_shift;
                quot_q <= {quot_q[SUM_W-2:0], 1'b0};
            end
            div_bit_q <= div_bit_q - 4'h1;
        end
    end

    // Filtered output and touch decision once per second-stage period
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            FILTERED_DATA <= '0;
            FILTERED_VALID <= 1'b0;
            TOUCH <= 1'b0;
        end else begin
            FILTERED_VALID <= 1'b0;
            if (state_q == cap_filter_pkg::ST_DIVIDE && div_bit_q == 4'h0) begin
                FILTERED_DATA <= DATA_W'({quot_q[SUM_W-2:0],
                    (rem_shift >= SUM_W'(second_target))});
                FILTERED_VALID <= 1'b1;
            end
            if (FILTERED_VALID) begin
                TOUCH <= (BASELINE > FILTERED_DATA) &&
                    ((BASELINE - FILTERED_DATA) >= TOUCH_THRESHOLD);
            end
        end
    end
endmodule

// ### tb/cap_filter_properties.sv
// Port-level assertions for the capacitive sensing filter block.
// Assumes the single-clock register port and status inputs of the block.
`timescale 1ns/1ps
`include "cap_filter_defines.svh"
module cap_filter_properties #(
    parameter int DATA_W = 10,
    parameter int unsigned INTERVAL_BASE_CYCLES = 40000
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic [DATA_W-1:0] ADC_DATA,
    input wire logic CHARGE_EN,
    input wire logic [5:0] CHARGE_CURRENT,
    input wire logic RANGE_FAIL_DONE,
    input wire logic RANGE_FAIL_RECONFIG,
    input wire logic [4:0] RANGE_FAIL_IN,
    input wire logic [DATA_W-1:0] BASELINE,
    input wire logic [DATA_W-1:0] TOUCH_THRESHOLD,
    input wire logic [DATA_W-1:0] FILTERED_DATA,
    input wire logic FILTERED_VALID,
    input wire logic TOUCH
);
    logic [7:0] fe_q;
    logic [7:0] fc_q;
    logic [7:0] st_q;
    logic [15:0] run_q;
    logic rd_st;
    assign rd_st = REG_RD && REG_ADDR == `ADDR_RANGE_FAIL_STATUS;
    always_ff @(posedge CLK_SYS) begin
        if (RESET) fe_q <= `RST_FRONT_END_CONFIG;
        else if (REG_WR && REG_ADDR == `ADDR_FRONT_END_CONFIG) fe_q <= REG_WDATA;
    end
    always_ff @(posedge CLK_SYS) begin
        if (RESET) fc_q <= `RST_FILTER_CONFIG;
        else if (REG_WR && REG_ADDR == `ADDR_FILTER_CONFIG) fc_q <= REG_WDATA;
    end
    always_ff @(posedge CLK_SYS) begin
        if (RESET) st_q <= 8'h00;
        else if (RANGE_FAIL_DONE) st_q <= {RANGE_FAIL_RECONFIG & |RANGE_FAIL_IN,
            !RANGE_FAIL_RECONFIG & |RANGE_FAIL_IN, 1'b0, RANGE_FAIL_IN};
    end
    // Length of the current charge phase, zero outside it
    always_ff @(posedge CLK_SYS) begin
        if (RESET || !CHARGE_EN) run_q <= 16'h0000;
        else run_q <= run_q + 16'h0001;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    AST_RECONFIG_FLAG: assert property (rd_st |=> REG_RDATA[7] == $past(st_q[7]))
        else $error("reconfiguration fail flag mismatch");
    AST_INITIAL_FLAG: assert property (rd_st |=> REG_RDATA[6] == $past(st_q[6]))
        else $error("initial configuration fail flag mismatch");
    AST_PROX_FAIL: assert property (rd_st |=> REG_RDATA[4] == $past(st_q[4]))
        else $error("proximity fail bit mismatch");
    AST_ELECTRODE_FAIL: assert property (rd_st |=> REG_RDATA[3:0] == $past(st_q[3:0]))
        else $error("electrode fail bits mismatch");
    AST_RESERVED_ZERO: assert property (rd_st |=> !REG_RDATA[5])
        else $error("reserved status bit set");
    AST_FRONT_END_READ: assert property (REG_RD && REG_ADDR == `ADDR_FRONT_END_CONFIG
        |=> REG_RDATA == $past(fe_q)) else $error("front end config readback wrong");
    AST_FILTER_READ: assert property (REG_RD && REG_ADDR == `ADDR_FILTER_CONFIG
        |=> REG_RDATA == $past(fc_q)) else $error("filter config readback wrong");
    AST_CHARGE_GATE: assert property ($rose(CHARGE_EN)
        |-> CHARGE_CURRENT != 6'h00 && fc_q[7:5] != 3'h0) else $error("charge while disabled");
    AST_CHARGE_TIME: assert property ($fell(CHARGE_EN)
        |-> run_q == (16'(`CHARGE_BASE_CYCLES) << (fc_q[7:5] - 3'h1)))
        else $error("charge phase length wrong");
    AST_TOUCH_TIMING: assert property ($changed(TOUCH) |-> $past(FILTERED_VALID))
        else $error("touch changed outside decision slot");
    AST_DATA_HOLD: assert property ($changed(FILTERED_DATA) |-> FILTERED_VALID)
        else $error("filtered data changed without valid");
endmodule
bind cap_sense_filter_timing cap_filter_properties #(.DATA_W(DATA_W),
    .INTERVAL_BASE_CYCLES(INTERVAL_BASE_CYCLES)) cap_filter_properties_i (
    .CLK_SYS, .RESET, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
    .ADC_DATA, .CHARGE_EN, .CHARGE_CURRENT, .RANGE_FAIL_DONE,
    .RANGE_FAIL_RECONFIG, .RANGE_FAIL_IN, .BASELINE, .TOUCH_THRESHOLD,
    .FILTERED_DATA, .FILTERED_VALID, .TOUCH);

// ### tb/electrode_model.sv
// Electrode front end model: one conversion per charge phase.
// Assumes the conversion is taken in the low cycle after each phase.
`timescale 1ns/1ps
module electrode_model #(
    parameter int DATA_W = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic charge_en,
    input wire logic [DATA_W-1:0] level,
    output logic [DATA_W-1:0] adc_data
);
    logic [5:0] k_q;
    logic [1:0] low_q;
    logic tog_q;
    logic [DATA_W-1:0] sample;
    always_ff @(posedge clk) tog_q <= reset ? 1'b0 : ~tog_q;
    always_ff @(posedge clk) begin
        if (reset) low_q <= 2'h3;
        else if (charge_en) low_q <= 2'h0;
        else if (low_q != 2'h3) low_q <= low_q + 2'h1;
    end
    // A second low cycle in a row ends the burst
    always_ff @(posedge clk) begin
        if (reset || (!charge_en && low_q == 2'h1)) k_q <= 6'h00;
        else if (!charge_en && low_q == 2'h0) k_q <= k_q + 6'h01;
    end
    // First sample is the maximum, second the minimum, the rest cancel in
    // pairs, so only a correct trim and average returns the level
    always_comb begin
        if (k_q == 6'h00) sample = level + DATA_W'(8'h28);
        else if (k_q == 6'h01) sample = level - DATA_W'(8'h28);
        else if (k_q[0]) sample = level + DATA_W'(1'b1);
        else sample = level - DATA_W'(1'b1);
    end
    // Outside the conversion slot the line toggles, so a mistimed capture shows
    assign adc_data = (!charge_en && low_q == 2'h0) ? sample
        : sample ^ DATA_W'({16{tog_q, ~tog_q}});
endmodule

// ### tb/test_cap_sense_filter_timing.sv
// Self-checking bench for the filter block over its own register port.
// Assumes the electrode model on the front end and the bound checker.
`timescale 1ns/1ps
`include "cap_filter_defines.svh"
module test_cap_sense_filter_timing;
    localparam int unsigned BASE = 400;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic done = 1'b0;
    logic reconfig = 1'b0;
    logic charge_q = 1'b0;
    logic charge_en, filtered_valid, touch;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [4:0] fail_in = 5'h00;
    logic [5:0] charge_current;
    logic [9:0] adc_data, filtered_data;
    logic [9:0] level = 10'h12c;
    logic [9:0] baseline = 10'h000;
    logic [9:0] threshold = 10'h028;
    logic st_rec [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [4:0] st_in [5] = '{5'h01, 5'h10, 5'h00, 5'h0f, 5'h1e};
    logic [7:0] st_want [5] = '{8'h81, 8'h50, 8'h00, 8'h4f, 8'h9e};
    int error_cnt = 0;
    int checks = 0;
    int cycle = 0;
    int rises = 0;

    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycle <= cycle + 1;
        charge_q <= charge_en;
        if (charge_en === 1'b1 && charge_q === 1'b0) rises <= rises + 1;
    end

    cap_sense_filter_timing #(.DATA_W(10), .INTERVAL_BASE_CYCLES(BASE))
        cap_sense_filter_timing_i (.CLK_SYS(clk_sys), .RESET(reset),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .ADC_DATA(adc_data),
        .CHARGE_EN(charge_en), .CHARGE_CURRENT(charge_current),
        .RANGE_FAIL_DONE(done), .RANGE_FAIL_RECONFIG(reconfig),
        .RANGE_FAIL_IN(fail_in), .BASELINE(baseline),
        .TOUCH_THRESHOLD(threshold), .FILTERED_DATA(filtered_data),
        .FILTERED_VALID(filtered_valid), .TOUCH(touch));
    electrode_model #(.DATA_W(10)) electrode_model_i (.clk(clk_sys),
        .reset(reset), .charge_en(charge_en), .level(level),
        .adc_data(adc_data));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want,
            input string what);
        checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what,
                seen, want);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic read_check(input logic [7:0] a, input logic [7:0] want,
            input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'(want), what);
    endtask
    task automatic fail_report(input logic rec, input logic [4:0] fails);
        @(posedge clk_sys);
        done <= 1'b1;
        reconfig <= rec;
        fail_in <= fails;
        @(posedge clk_sys);
        done <= 1'b0;
    endtask
    // Bounded, since a stalled filter would otherwise hang the run
    task automatic wait_valid(output int at);
        int n;
        for (n = 0; n < 40000; n++) begin
            @(posedge clk_sys);
            #1;
            if (filtered_valid === 1'b1) break;
        end
        at = cycle;
        if (n == 40000) begin
            error_cnt++;
            $display("wrong value at %0t: no filtered output", $time);
            wrap_up();
        end
    endtask
    // Configs are written just after an output, between bursts; the first
    // output after that is partial and only the next window is judged
    task automatic run_row(input logic [7:0] fe, input logic [7:0] fc,
            input int n1, input int n2, input int period,
            input logic [9:0] lvl, input logic [9:0] base, input logic tch);
        int t1;
        int t2;
        int c1;
        @(posedge clk_sys);
        level <= lvl;
        baseline <= base;
        // The host's auto-configuration copy of the count lives elsewhere
        reg_write(`ADDR_FRONT_END_CONFIG, fe);
        reg_write(`ADDR_FILTER_CONFIG, fc);
        #1;
        check(16'(charge_current), 16'(fe[5:0]), "current code");
        wait_valid(t1);
        c1 = rises;
        wait_valid(t2);
        check(16'(t2 - t1), 16'(period * n2), "output period");
        check(16'(rises - c1), 16'(n1 * n2), "charge phases");
        check(16'(filtered_data), 16'(lvl), "filtered data");
        @(posedge clk_sys);
        #1;
        check(16'(touch), 16'(tch), "touch decision");
        $display("row %h %h done", fe, fc);
    endtask

    initial begin
        int c;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        read_check(`ADDR_FRONT_END_CONFIG, `RST_FRONT_END_CONFIG, "fe reset");
        read_check(`ADDR_FILTER_CONFIG, `RST_FILTER_CONFIG, "fc reset");
        read_check(`ADDR_RANGE_FAIL_STATUS, 8'h00, "status reset");
        reg_write(`ADDR_RANGE_FAIL_STATUS, 8'hff);
        read_check(`ADDR_RANGE_FAIL_STATUS, 8'h00, "status write");
        read_check(8'h7e, 8'h00, "unmapped read");
        reg_write(`ADDR_FRONT_END_CONFIG, 8'ha5);
        read_check(`ADDR_FRONT_END_CONFIG, 8'ha5, "fe readback");
        reg_write(`ADDR_FILTER_CONFIG, 8'hb4);
        read_check(`ADDR_FILTER_CONFIG, 8'hb4, "fc readback");
        $display("register test done");
        for (int i = 0; i < 5; i++) begin
            fail_report(st_rec[i], st_in[i]);
            read_check(`ADDR_RANGE_FAIL_STATUS, st_want[i], "status");
        end
        @(posedge clk_sys);
        done <= 1'b1;
        reconfig <= 1'b1;
        fail_in <= 5'h1f;
        @(posedge clk_sys);
        reconfig <= 1'b0;
        fail_in <= 5'h02;
        @(posedge clk_sys);
        done <= 1'b0;
        read_check(`ADDR_RANGE_FAIL_STATUS, 8'h42, "status back to back");
        $display("status test done");
        run_row(8'h05, 8'h20, 6, 4, 400, 10'h12c, 10'h15e, 1'b1);
        run_row(8'h4c, 8'h49, 10, 6, 800, 10'h1f4, 10'h208, 1'b0);
        run_row(8'hbf, 8'h31, 18, 10, 800, 10'h064, 10'h08c, 1'b1);
        run_row(8'hc1, 8'h39, 34, 18, 800, 10'h384, 10'h370, 1'b0);
        run_row(8'h20, 8'h62, 6, 4, 1600, 10'h258, 10'h2bc, 1'b1);
        reg_write(`ADDR_FRONT_END_CONFIG, 8'h00);
        c = rises;
        repeat (12 * BASE) @(posedge clk_sys);
        check(16'(rises - c), 16'h0000, "zero current");
        reg_write(`ADDR_FILTER_CONFIG, 8'h02);
        reg_write(`ADDR_FRONT_END_CONFIG, 8'h20);
        c = rises;
        repeat (12 * BASE) @(posedge clk_sys);
        check(16'(rises - c), 16'h0000, "invalid charge time");
        $display("suppression test done");
        reset <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        read_check(`ADDR_FRONT_END_CONFIG, `RST_FRONT_END_CONFIG, "fe rereset");
        read_check(`ADDR_RANGE_FAIL_STATUS, 8'h00, "status rereset");
        $display("reset test done");
        wrap_up();
    end
endmodule
